// *** hw/fixed_cycle_countdown_timer.sv ***
// Periodic countdown timer with event flag and open-drain interrupt
// Functional notes
// - With enable low, counter reads return the preset value.
// - Clearing enable halts counting but keeps a held-low interrupt low.
// - Enable 0-to-1 starts counting, always loading the preset first.
// - Timer event sets the event flag; it stays set until cleared.
// - Writing 0 clears the flag; held-low interrupt stays low.
// - Writing 1 to the event flag changes nothing.
// - Interrupt enable low blocks assertion and releases a held interrupt.
// - Interrupt enable high lets an event pull the interrupt low.
// - Power-domain select restricts counting to main or backup supply.
// - With halt and domain select off, pause stops and resumes counting.
// - Resume continues from the held count, not from the preset.
// - With domain select on, pause is ignored.
// - Clock halt stops counting for all sources except 4096 Hz.
// - Counting begins at the next rising SCL edge after enabling write.
// - Interval equals preset count times source period; preset 0 undefined.
// - Three-bit source select picks 4096, 64, 1 Hz, minute or hour.
// - A count step at 1 raises event and loads preset, not 0; repeats.
// - Interrupt releases itself after 122 us at 4096 Hz, else 7.813 ms.
`timescale 1ns/1ps
module fixed_cycle_countdown_timer #(
  parameter int RELEASE_SLOW = countdown_timer_pkg::RELEASE_SLOW_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire countdown_timer_pkg::timer_ctrl_t i_ctrl,
  input wire logic [15:0] i_preset,
  input wire logic [4:0] i_src_ticks,
  input wire logic i_on_backup,
  input wire logic i_scl,
  input wire logic i_flag_write,
  input wire logic i_flag_wdata,
  output logic [15:0] o_count_read,
  output logic o_timer_event_flag,
  output logic o_irq_out,
  output logic o_irq_oe
);
  countdown_timer_pkg::timer_state_t state;
  countdown_timer_pkg::timer_state_t next_state;
  logic [1:0] scl_sync;
  logic [1:0] backup_sync;
  logic scl_prev;
  logic enable_prev;
  logic [15:0] count;
  logic [15:0] next_count;
  logic irq_low;
  logic [17:0] release_cnt;
  logic [17:0] release_load;
  logic timer_event;

  // Pin inputs pass two flops; edge finder reads only the second
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_sync <= 2'h3; // SCL idles high; no false edge after reset
      backup_sync <= 2'h0;
      scl_prev <= 1'b1;
      enable_prev <= 1'b0;
    end else begin
      scl_sync <= {scl_sync[0], i_scl};
      backup_sync <= {backup_sync[0], i_on_backup};
      scl_prev <= scl_sync[1];
      enable_prev <= i_ctrl.timer_enable;
    end
  end

  // Source selection and counting gates
  wire [2:0] src_sel = {i_ctrl.source_sel_b2, i_ctrl.source_sel_b1,
                        i_ctrl.source_sel_b0};
  wire scl_rise = scl_sync[1] && !scl_prev;
  wire enable_rise = i_ctrl.timer_enable && !enable_prev;
  wire src_is_fast = (src_sel == countdown_timer_pkg::SRC_4096HZ);
  wire src_valid = (src_sel <= countdown_timer_pkg::SRC_1HOUR);
  wire src_tick = src_valid && i_src_ticks[src_sel];
  wire domain_ok = !i_ctrl.power_domain_select ||
                   (i_ctrl.power_domain_bit == backup_sync[1]);
  wire pause_on = i_ctrl.timer_pause &&
                  !i_ctrl.power_domain_select;
  wire halt_on = i_ctrl.clock_halt && !src_is_fast;
  wire count_step = (state == countdown_timer_pkg::ST_RUN) && src_tick &&
                    domain_ok && !pause_on && !halt_on;
  assign timer_event = count_step && (count == 16'h0001);
  assign release_load = src_is_fast ?
    18'(countdown_timer_pkg::RELEASE_FAST_CYCLES) :
    18'(RELEASE_SLOW);
  // Largest reload the hold counter can ever take
  wire [17:0] release_max =
    (countdown_timer_pkg::RELEASE_FAST_CYCLES > RELEASE_SLOW) ?
    18'(countdown_timer_pkg::RELEASE_FAST_CYCLES) : 18'(RELEASE_SLOW);

  // Countdown state: idle, armed for SCL edge, running
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      countdown_timer_pkg::ST_IDLE: begin
        if (enable_rise) begin
          next_state = countdown_timer_pkg::ST_ARMED;
        end
      end
      countdown_timer_pkg::ST_ARMED: begin
        if (!i_ctrl.timer_enable) begin
          next_state = countdown_timer_pkg::ST_IDLE;
        end else if (scl_rise) begin
          next_state = countdown_timer_pkg::ST_RUN;
          next_count = i_preset;
        end
      end
      countdown_timer_pkg::ST_RUN: begin
        if (!i_ctrl.timer_enable) begin
          next_state = countdown_timer_pkg::ST_IDLE;
        end else if (timer_event) begin
          next_count = i_preset;
        end else if (count_step && count != 16'h0000) begin
          next_count = count - 16'h0001;
        end
      end
      default: begin
        next_state = countdown_timer_pkg::ST_IDLE;
      end
    endcase
  end

  // State and count registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= countdown_timer_pkg::ST_IDLE;
      count <= countdown_timer_pkg::COUNT_RESET;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // Event flag: event wins over a clear; writing 1 is ignored
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_timer_event_flag <= 1'b0;
    end else if (timer_event) begin
      o_timer_event_flag <= 1'b1;
    end else if (i_flag_write && !i_flag_wdata) begin
      o_timer_event_flag <= 1'b0;
    end
  end

  // Interrupt hold; only auto release or interrupt enable low frees it
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_low <= 1'b0;
      release_cnt <= countdown_timer_pkg::RELEASE_RESET;
    end else if (timer_event && i_ctrl.timer_irq_enable) begin
      irq_low <= 1'b1;
      release_cnt <= release_load;
    end else if (!i_ctrl.timer_irq_enable) begin
      irq_low <= 1'b0;
      release_cnt <= countdown_timer_pkg::RELEASE_RESET;
    end else if (irq_low) begin
      if (release_cnt <= 18'h00001) begin
        irq_low <= 1'b0;
      end
      release_cnt <= release_cnt - 18'h00001;
    end
  end

  // Outputs: open-drain pin drives only low
  assign o_irq_out = 1'b0;
  assign o_irq_oe = irq_low && i_ctrl.timer_irq_enable;
  assign o_count_read = i_ctrl.timer_enable ? count : i_preset;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  chk_read_preset: assert property (
    !i_ctrl.timer_enable |-> o_count_read == i_preset)
    else $error("preset not shown while disabled");
  chk_flag_sticky: assert property (
    o_timer_event_flag && !(i_flag_write && !i_flag_wdata)
    |=> o_timer_event_flag)
    else $error("event flag lost without clear");
  chk_flag_clear: assert property (
    i_flag_write && !i_flag_wdata && !timer_event |=> !o_timer_event_flag)
    else $error("event flag not cleared");
  chk_flag_one_write: assert property (
    i_flag_write && i_flag_wdata && !timer_event
    |=> o_timer_event_flag == $past(o_timer_event_flag))
    else $error("writing one changed the flag");
  chk_irq_gated: assert property (
    !i_ctrl.timer_irq_enable |-> !o_irq_oe)
    else $error("interrupt driven while disabled");
  chk_irq_assert: assert property (
    timer_event && i_ctrl.timer_irq_enable && i_ctrl.timer_irq_enable
    ##1 i_ctrl.timer_irq_enable |-> o_irq_oe)
    else $error("event did not pull interrupt low");
  chk_irq_survives: assert property (
    o_irq_oe && release_cnt > 18'h00002 ##1 i_ctrl.timer_irq_enable
    |-> o_irq_oe)
    else $error("interrupt released early");
  chk_start_preset: assert property (
    state == countdown_timer_pkg::ST_ARMED && i_ctrl.timer_enable &&
    scl_rise |=> count == $past(i_preset) &&
    state == countdown_timer_pkg::ST_RUN)
    else $error("countdown did not start from preset");
  chk_pause_hold: assert property (
    state == countdown_timer_pkg::ST_RUN && pause_on &&
    i_ctrl.timer_enable |=> count == $past(count))
    else $error("count moved while paused");
  chk_halt_hold: assert property (
    state == countdown_timer_pkg::ST_RUN && halt_on &&
    i_ctrl.timer_enable |=> count == $past(count))
    else $error("count moved while halted");
  chk_reload: assert property (
    timer_event && i_ctrl.timer_enable |=> count == $past(i_preset))
    else $error("no reload after event");
  chk_release_bound: assert property (
    release_cnt <= release_max &&
    (!irq_low || release_cnt != 18'h00000))
    else $error("release count out of range");
  chk_armed_wait: assert property (
    state == countdown_timer_pkg::ST_ARMED && !scl_rise |=>
    state != countdown_timer_pkg::ST_RUN && count == $past(count))
    else $error("countdown started before SCL edge");

  cov_event: cover property (timer_event);
  cov_armed_start: cover property (
    state == countdown_timer_pkg::ST_ARMED && scl_rise);
  cov_irq_release: cover property (o_irq_oe ##1 !o_irq_oe);
  cov_pause_resume: cover property (
    state == countdown_timer_pkg::ST_RUN && pause_on ##1 !pause_on);
endmodule

// *** hw/countdown_timer_pkg.sv ***
// Package with constants and types for the periodic countdown timer
package countdown_timer_pkg;
  // Source select encodings
  localparam logic [2:0] SRC_4096HZ = 3'h0;
  localparam logic [2:0] SRC_64HZ = 3'h1;
  localparam logic [2:0] SRC_1HZ = 3'h2;
  localparam logic [2:0] SRC_1MIN = 3'h3;
  localparam logic [2:0] SRC_1HOUR = 3'h4;
  // Clock and auto release times
  localparam int CLOCK_PERIOD_PS = 40000;
  localparam int RELEASE_FAST_PS = 122000000;
  localparam int RELEASE_SLOW_NS = 7813000;
  localparam int RELEASE_FAST_CYCLES = RELEASE_FAST_PS / CLOCK_PERIOD_PS;
  localparam int RELEASE_SLOW_CYCLES =
    RELEASE_SLOW_NS / (CLOCK_PERIOD_PS / 1000);
  // Reset values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [17:0] RELEASE_RESET = 18'h00000;
  // Control bits of the timer, as held in the device's registers
  typedef struct packed {
    logic timer_enable;
    logic timer_irq_enable;
    logic timer_pause;
    logic power_domain_select;
    logic power_domain_bit;
    logic clock_halt;
    logic source_sel_b2;
    logic source_sel_b1;
    logic source_sel_b0;
  } timer_ctrl_t;
  // Countdown state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_RUN = 3'b100
  } timer_state_t;
endpackage

// *** tb/scl_host_model.sv ***
// Host model that clocks SCL only while a write frame is open
`timescale 1ns/1ps
module scl_host_model (
  input wire logic i_frame,
  output logic o_scl
);
  // SCL rests high on its pull-up and toggles every 160 ns in frames
  initial begin
    o_scl = 1'b1;
    forever begin
      wait (i_frame);
      while (i_frame) begin
        #160 o_scl = 1'b0;
        #160 o_scl = 1'b1; // Ack clock rise
      end
    end
  end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the periodic countdown timer
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [2:0] sel; logic [15:0] pre;} row_t;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  countdown_timer_pkg::timer_ctrl_t ctrl = '0;
  logic [15:0] preset = 16'h0000;
  logic [4:0] ticks = 5'h00;
  logic on_backup = 1'b0;
  logic frame = 1'b0;
  logic fw = 1'b0;
  logic fd = 1'b0;
  logic scl, flag, irq, oe;
  logic [15:0] count;
  int failures = 0;
  int cmp_count = 0;
  row_t rows [5] = '{'{3'h0, 16'h0003}, '{3'h1, 16'h0001},
    '{3'h2, 16'h0002}, '{3'h3, 16'h0004}, '{3'h4, 16'h0002}};
  // Clock, host model and timer
  always #20 i_clock = ~i_clock;
  scl_host_model u_host (.i_frame(frame), .o_scl(scl));
  fixed_cycle_countdown_timer #(.RELEASE_SLOW(20)) u_dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_ctrl(ctrl),
    .i_preset(preset), .i_src_ticks(ticks), .i_on_backup(on_backup),
    .i_scl(scl), .i_flag_write(fw), .i_flag_wdata(fd),
    .o_count_read(count), .o_timer_event_flag(flag),
    .o_irq_out(irq), .o_irq_oe(oe));
  // Bench helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic tick(input int b);
    ticks[b] = 1'b1;
    cyc(1);
    ticks = 5'h00;
    cyc(1);
  endtask
  task automatic setsrc(input logic [2:0] s);
    {ctrl.source_sel_b2, ctrl.source_sel_b1, ctrl.source_sel_b0} = s;
  endtask
  task automatic wflag(input logic v);
    fw = 1'b1;
    fd = v;
    cyc(1);
    fw = 1'b0;
    cyc(1);
  endtask
  task automatic start();
    ctrl.timer_enable = 1'b0;
    cyc(2);
    ctrl.timer_enable = 1'b1;
    cyc(1);
    ticks = 5'h1f; // Ticks while armed must not count
    cyc(1);
    ticks = 5'h00;
    frame = 1'b1;
    cyc(12);
    frame = 1'b0;
    cyc(10);
  endtask
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #2000000;
    failures++;
    stop_test();
  end
  // Main sequence: table rows, then hand-written cases
  initial begin
    ctrl.timer_irq_enable = 1'b1;
    cyc(4);
    i_rst_n = 1'b1;
    chk({13'h0, flag, oe, irq}, 16'h0000);
    foreach (rows[i]) begin
      setsrc(rows[i].sel);
      preset = rows[i].pre;
      ctrl.timer_enable = 1'b0;
      cyc(2);
      chk(count, preset);
      start();
      chk(count, preset);
      repeat (rows[i].pre - 16'h0001) tick(rows[i].sel);
      chk({count[14:0], flag}, 16'h0002);
      tick(rows[i].sel);
      chk({14'h0, flag, oe}, 16'h0003);
      chk(count, preset);
      cyc(rows[i].sel == 3'h0 ? 3040 : 10);
      chk(16'(oe), 16'h0001);
      cyc(20);
      chk({14'h0, flag, oe}, 16'h0002);
      wflag(1'b0);
      chk(16'(flag), 16'h0000);
    end
    // Pause, domain select, halt and source choice
    setsrc(3'h1);
    preset = 16'h0008;
    start();
    tick(1);
    ctrl.timer_pause = 1'b1;
    tick(1);
    chk(count, 16'h0007);
    ctrl.timer_pause = 1'b0;
    tick(1);
    chk(count, 16'h0006);
    ctrl.power_domain_select = 1'b1;
    ctrl.timer_pause = 1'b1;
    tick(1);
    chk(count, 16'h0005);
    ctrl.power_domain_bit = 1'b1;
    tick(1);
    chk(count, 16'h0005);
    on_backup = 1'b1;
    cyc(4);
    tick(1);
    chk(count, 16'h0004);
    ctrl.power_domain_select = 1'b0;
    ctrl.timer_pause = 1'b0;
    ctrl.clock_halt = 1'b1;
    tick(1);
    chk(count, 16'h0004);
    setsrc(3'h0);
    tick(0);
    tick(2);
    chk(count, 16'h0003);
    ctrl.clock_halt = 1'b0;
    setsrc(3'h5);
    tick(0);
    tick(4);
    chk(count, 16'h0003);
    setsrc(3'h0);
    tick(0);
    wflag(1'b1);
    chk(16'(flag), 16'h0000);
    tick(0);
    tick(0);
    wflag(1'b1);
    chk({14'h0, flag, oe}, 16'h0003);
    wflag(1'b0);
    chk({14'h0, flag, oe}, 16'h0001);
    ctrl.timer_enable = 1'b0;
    tick(0);
    chk({oe, count[14:0]}, 16'h8008);
    ctrl.timer_irq_enable = 1'b0;
    cyc(1);
    chk(16'(oe), 16'h0000);
    // Event with interrupt enable low leaves the pin released
    preset = 16'h0001;
    start();
    tick(0);
    chk({14'h0, flag, oe}, 16'h0002);
    // Mid-run reset clears the flag and must not start a countdown
    i_rst_n = 1'b0;
    cyc(2);
    chk({14'h0, flag, oe}, 16'h0000);
    i_rst_n = 1'b1;
    cyc(4);
    chk(count, 16'h0000);
    stop_test();
  end
endmodule
